//--- core/stc_stats_counter_indirect_read.sv
// Indirect read port for per-port statistics counters and dropped counters.
// Assumes a byte-wide host register port with single-cycle strobes.
`timescale 1ns/1ps
`include "stc_defs.svh"

module stc_stats_counter_indirect_read import stc_pkg::*; #(
   parameter int NUM_PORTS = 5,
   parameter int CNT_PER_PORT = 32,
   parameter int CNT_WIDTH = 30,
   parameter int DROP_WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Host register port
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Counter events, one pulse per count
   input wire logic [NUM_PORTS*CNT_PER_PORT-1:0] portCntEvt,
   input wire logic [NUM_PORTS-1:0] txDropEvt,
   input wire logic [NUM_PORTS-1:0] rxDropEvt
);

   localparam int NUM_CNT = NUM_PORTS * CNT_PER_PORT;
   localparam int NUM_DROP = 2 * NUM_PORTS;

   // ==========================================================
   // Helper functions
   function automatic stc_kind_e selKind(input logic [7:0] sel);
      stc_kind_e k;
      k = STC_KIND_NONE;
      if (sel == `STC_SEL_PORT_CNT) begin
         k = STC_KIND_PORT;
      end else if (sel == `STC_SEL_DROP_CNT) begin
         k = STC_KIND_DROP;
      end
      return k;
   endfunction

   function automatic logic [7:0] wordByte(input logic [31:0] w,
                                           input logic [1:0] n);
      logic [7:0] b;
      b = w[8*n +: 8];
      return b;
   endfunction

   // ==========================================================
   // Counter storage
   logic [CNT_WIDTH-1:0] cntVal [NUM_CNT];
   logic cntOvf [NUM_CNT];
   logic [NUM_CNT-1:0] clrVec;
   logic [DROP_WIDTH-1:0] dropVal [NUM_DROP];
   logic [NUM_DROP-1:0] dropEvt;

   // Index 0..4 is transmit, 5..9 is receive, matching the offset order
   assign dropEvt = {rxDropEvt, txDropEvt};

   // Offset within a port's set selects rx (low) or tx (high) counters
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CNT; gi++) begin : gPortCnt
         stc_stat_counter #(
            .WIDTH(CNT_WIDTH)
         ) uCnt (
            .clk(clk),
            .resetn(resetn),
            .countEvt(portCntEvt[gi]),
            .clearPulse(clrVec[gi]),
            .countVal(cntVal[gi]),
            .overflow(cntOvf[gi])
         );
      end
      for (gi = 0; gi < NUM_DROP; gi++) begin : gDropCnt
         stc_drop_counter #(
            .WIDTH(DROP_WIDTH)
         ) uDrop (
            .clk(clk),
            .resetn(resetn),
            .countEvt(dropEvt[gi]),
            .countVal(dropVal[gi])
         );
      end
   endgenerate

   // ==========================================================
   // State
   stc_state_s st_reg;
   stc_state_s st_next;
   stc_iaddr_t iAddr;
   stc_kind_e fetchKind;
   logic trigWr;
   logic fetchPort;
   logic fetchDrop;
   logic [7:0] fetchIdx;
   logic [3:0] dropIdx;

   // Trigger byte sits under table select bit 0
   assign iAddr = {st_reg.tableSel[`STC_SEL_ADDR8_BIT],
                   regWrData};
   assign fetchKind = selKind(st_reg.tableSel);
   assign trigWr = regWrEn && (regAddr == `STC_REG_ADDR_TRIG);
   // Port stride equals the set size, so the offset is the flat index
   assign fetchIdx = iAddr[7:0];
   assign dropIdx = 4'(iAddr - `STC_TX_DROP_BASE);
   assign fetchPort = trigWr && (fetchKind == STC_KIND_PORT) &&
                      (iAddr < `STC_PORT_SPACE_END);
   assign fetchDrop = trigWr && (fetchKind == STC_KIND_DROP) &&
                      (iAddr >= `STC_TX_DROP_BASE) &&
                      (iAddr < `STC_DROP_SPACE_END);

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.rdValid = 1'b0;
      clrVec = '0;
      if (regWrEn) begin
         if (regAddr == `STC_REG_TABLE_SEL) begin
            st_next.tableSel = regWrData;
         end else if (regAddr == `STC_REG_ADDR_TRIG) begin
            st_next.addrTrig = regWrData;
            case (fetchKind)
               STC_KIND_PORT: begin
                  // Out-of-range offsets return zero with valid low
                  st_next.dataWord = `STC_DATA_WORD_RST;
                  if (fetchPort) begin
                     st_next.dataWord[`STC_OVF_BIT] =
                        cntOvf[fetchIdx];
                     st_next.dataWord[`STC_VALID_BIT] = 1'b1;
                     st_next.dataWord[`STC_VALUE_MSB:0] =
                        30'(cntVal[fetchIdx]);
                     clrVec[fetchIdx] = 1'b1;
                  end
               end
               STC_KIND_DROP: begin
                  st_next.dataWord = `STC_DATA_WORD_RST;
                  if (fetchDrop) begin
                     st_next.dataWord[`STC_DROP_MSB:0] =
                        16'(dropVal[dropIdx]);
                  end
               end
               // Other tables belong elsewhere; captured word is kept
               default: begin
                  st_next.dataWord = st_reg.dataWord;
               end
            endcase
         end
      end
      if (regRdEn) begin
         st_next.rdValid = 1'b1;
         case (regAddr)
            `STC_REG_TABLE_SEL: st_next.rdData = st_reg.tableSel;
            `STC_REG_ADDR_TRIG: st_next.rdData = st_reg.addrTrig;
            // Reading data has no side effect on any counter
            `STC_REG_DATA_3: begin
               st_next.rdData = wordByte(st_reg.dataWord, 2'd3);
            end
            `STC_REG_DATA_2: begin
               st_next.rdData = wordByte(st_reg.dataWord, 2'd2);
            end
            `STC_REG_DATA_1: begin
               st_next.rdData = wordByte(st_reg.dataWord, 2'd1);
            end
            `STC_REG_DATA_0: begin
               st_next.rdData = wordByte(st_reg.dataWord, 2'd0);
            end
            default: st_next.rdData = `STC_RD_DATA_RST;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg.tableSel <= `STC_TABLE_SEL_RST;
         st_reg.addrTrig <= `STC_ADDR_TRIG_RST;
         st_reg.dataWord <= `STC_DATA_WORD_RST;
         st_reg.rdData <= `STC_RD_DATA_RST;
         st_reg.rdValid <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign regRdData = st_reg.rdData;
   assign regRdValid = st_reg.rdValid;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   port_value_fetch_a: assert property (
      fetchPort |=> st_reg.dataWord[29:0] == $past(cntVal[fetchIdx]))
      else $error("fetched per-port value does not match counter");

   overflow_flag_a: assert property (
      fetchPort |=> st_reg.dataWord[31] == $past(cntOvf[fetchIdx]))
      else $error("overflow flag does not match counter");

   valid_flag_a: assert property (
      trigWr && fetchKind == STC_KIND_PORT
      |=> st_reg.dataWord[30] == $past(fetchPort))
      else $error("valid flag wrong for fetched offset");

   drop_value_a: assert property (
      fetchDrop
      |=> st_reg.dataWord == {16'h0000, $past(dropVal[dropIdx])})
      else $error("dropped counter word wrong");

   byte_order_a: assert property (
      regRdEn && regAddr == `STC_REG_DATA_3
      |=> regRdValid && regRdData == $past(st_reg.dataWord[31:24]))
      else $error("top data byte wrong");

   low_byte_a: assert property (
      regRdEn && regAddr == `STC_REG_DATA_0
      |=> regRdValid && regRdData == $past(st_reg.dataWord[7:0]))
      else $error("low data byte wrong");

   clear_on_read_a: assert property (
      fetchPort
      |=> cntVal[$past(fetchIdx)] == 30'($past(portCntEvt[fetchIdx])))
      else $error("per-port counter not cleared by fetch");

   drop_kept_a: assert property (
      fetchDrop && !dropEvt[dropIdx]
      |=> dropVal[$past(dropIdx)] == $past(dropVal[dropIdx]))
      else $error("dropped counter changed by read");

   read_pure_a: assert property (
      !trigWr |=> $stable(st_reg.dataWord))
      else $error("data word changed without trigger write");

   other_table_a: assert property (
      trigWr && fetchKind == STC_KIND_NONE |=> $stable(st_reg.dataWord))
      else $error("data word changed for a foreign table");

   read_answer_a: assert property (
      regRdEn
      |=> regRdValid)
      else $error("read strobe got no answer");

   idle_answer_a: assert property (
      !regRdEn
      |=> !regRdValid)
      else $error("read answer without a read strobe");

   byte_two_a: assert property (
      regRdEn && regAddr == `STC_REG_DATA_2
      |=> regRdData == $past(st_reg.dataWord[23:16]))
      else $error("second data byte wrong");

   byte_one_a: assert property (
      regRdEn && regAddr == `STC_REG_DATA_1
      |=> regRdData == $past(st_reg.dataWord[15:8]))
      else $error("third data byte wrong");

   select_store_a: assert property (
      regWrEn && regAddr == `STC_REG_TABLE_SEL
      |=> st_reg.tableSel == $past(regWrData))
      else $error("table select not stored");

   trigger_store_a: assert property (
      regWrEn && regAddr == `STC_REG_ADDR_TRIG
      |=> st_reg.addrTrig == $past(regWrData))
      else $error("trigger byte not stored");

   port_range_a: assert property (
      trigWr && fetchKind == STC_KIND_PORT && !fetchPort
      |=> st_reg.dataWord == 32'h0000_0000)
      else $error("offset past last port gave a nonzero word");

   drop_range_a: assert property (
      trigWr && fetchKind == STC_KIND_DROP && !fetchDrop
      |=> st_reg.dataWord == 32'h0000_0000)
      else $error("offset past last drop counter gave a nonzero word");

   clear_single_a: assert property (
      clrVec != '0
      |-> fetchPort && $onehot(clrVec))
      else $error("counter cleared outside a single fetch");

endmodule

//--- core/stc_defs.svh
// Constants for the statistics counter indirect read block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

// ==========================================================
// Register offsets on the host register port
`define STC_REG_TABLE_SEL 8'h6E
`define STC_REG_ADDR_TRIG 8'h6F
`define STC_REG_DATA_3 8'h75
`define STC_REG_DATA_2 8'h76
`define STC_REG_DATA_1 8'h77
`define STC_REG_DATA_0 8'h78

// ==========================================================
// Table select codes and indirect address layout
`define STC_SEL_PORT_CNT 8'h1C
`define STC_SEL_DROP_CNT 8'h1D
`define STC_SEL_ADDR8_BIT 0
`define STC_PORT_STRIDE 9'h020
`define STC_PORT_SPACE_END 9'h0A0
`define STC_TX_DROP_BASE 9'h100
`define STC_RX_DROP_BASE 9'h105
`define STC_DROP_SPACE_END 9'h10A
`define STC_RX_FRAMES_64_OFS 5'h0E
`define STC_TX_FIRST_OFS 5'h14

// ==========================================================
// Returned word fields
`define STC_OVF_BIT 31
`define STC_VALID_BIT 30
`define STC_VALUE_MSB 29
`define STC_DROP_MSB 15

// ==========================================================
// Reset values
`define STC_TABLE_SEL_RST 8'h00
`define STC_ADDR_TRIG_RST 8'h00
`define STC_DATA_WORD_RST 32'h0000_0000
`define STC_RD_DATA_RST 8'h00

`endif

//--- core/stc_pkg.sv
// Types shared by the statistics counter indirect read block.
// Assumes stc_defs.svh is on the include path.
`include "stc_defs.svh"

package stc_pkg;

   // ==========================================================
   // Indirect address: table select bit 0 on top of trigger byte
   typedef logic [8:0] stc_iaddr_t;

   // ==========================================================
   // Kind of fetch selected by the table select code
   typedef enum logic [2:0] {
      STC_KIND_NONE = 3'h1,
      STC_KIND_PORT = 3'h2,
      STC_KIND_DROP = 3'h4
   } stc_kind_e;

   // ==========================================================
   // Whole state of the top module
   typedef struct packed {
      logic [7:0] tableSel;
      logic [7:0] addrTrig;
      logic [31:0] dataWord;
      logic [7:0] rdData;
      logic rdValid;
   } stc_state_s;

endpackage

//--- core/stc_stat_counter.sv
// One per-port statistics counter with sticky overflow, cleared on fetch.
// Assumes event and clear pulses synchronous to clk.
`timescale 1ns/1ps

module stc_stat_counter import stc_pkg::*; #(
   parameter int WIDTH = 30
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Count and clear
   input wire logic countEvt,
   input wire logic clearPulse,
   // State out
   output logic [WIDTH-1:0] countVal,
   output logic overflow
);

   typedef struct packed {
      logic ovf;
      logic [WIDTH-1:0] cnt;
   } stc_cnt_s;

   stc_cnt_s st_reg;
   stc_cnt_s st_next;

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      if (clearPulse) begin
         // An event in the clearing cycle is kept, not lost
         st_next.cnt = WIDTH'(countEvt);
         st_next.ovf = 1'b0;
      end else if (countEvt) begin
         st_next.cnt = st_reg.cnt + WIDTH'(1);
         if (&st_reg.cnt) begin
            st_next.ovf = 1'b1;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign countVal = st_reg.cnt;
   assign overflow = st_reg.ovf;

   // ==========================================================
   // Assertions
   clear_event_a: assert property (
      @(posedge clk) disable iff (!resetn)
      clearPulse
      |=> st_reg.cnt == WIDTH'($past(countEvt)) && !st_reg.ovf)
      else $error("counter clear lost an event or kept overflow");

   overflow_sticky_a: assert property (
      @(posedge clk) disable iff (!resetn)
      st_reg.ovf && !clearPulse
      |=> st_reg.ovf)
      else $error("overflow flag dropped without a fetch");

endmodule

//--- core/stc_drop_counter.sv
// One dropped-packet counter; wraps silently and is cleared only by reset.
// Assumes event pulses synchronous to clk.
`timescale 1ns/1ps

module stc_drop_counter import stc_pkg::*; #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Count
   input wire logic countEvt,
   // State out
   output logic [WIDTH-1:0] countVal
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } stc_drop_s;

   stc_drop_s st_reg;
   stc_drop_s st_next;

   // ==========================================================
   // Next state; no overflow tracking, software keeps that
   always_comb begin
      st_next = st_reg;
      if (countEvt) begin
         st_next.cnt = st_reg.cnt + WIDTH'(1);
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign countVal = st_reg.cnt;

endmodule

//--- verification/stc_stats_counter_indirect_read_bench.sv
// Self-checking bench for the statistics counter indirect read block.
// Assumes the design top and stc_pkg are compiled before this file.
`timescale 1ns/1ps
`include "stc_defs.svh"

// ==========================================================
// Compare macro: counts every check, reports and counts mismatches
`define STC_CHK(what, exp, got) \
   begin \
      nTests++; \
      if ((got) !== (exp)) begin \
         badCount++; \
         $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
      end \
   end

module stc_stats_counter_indirect_read_bench import stc_pkg::*;;

   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [159:0] portCntEvt = '0;
   logic [4:0] txDropEvt = 5'h00;
   logic [4:0] rxDropEvt = 5'h00;
   int badCount = 0;
   int nTests = 0;

   always #2 clk = ~clk;

   stc_stats_counter_indirect_read stc_stats_counter_indirect_read_inst (
      .clk(clk),
      .resetn(resetn),
      .regWrEn(regWrEn),
      .regRdEn(regRdEn),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .regRdValid(regRdValid),
      .portCntEvt(portCntEvt),
      .txDropEvt(txDropEvt),
      .rxDropEvt(rxDropEvt)
   );

   // ==========================================================
   // Host register port tasks, all driven on the falling edge
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask

   // Answer is registered on the taking edge, seen at the next falling edge; waits are bounded
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
      int k;
      @(negedge clk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRdEn = 1'b0;
      k = 0;
      while (regRdValid !== 1'b1 && k < 4) begin
         @(negedge clk);
         k++;
      end
      if (k == 4) begin
         badCount++;
         $display("unexpected read answer: expected valid seen none");
         endOfTest();
      end
      `STC_CHK("read latency", 0, k)
      `STC_CHK(nm, e, regRdData)
   endtask

   // Holding an event bit for n cycles gives n counts
   task automatic pulse(input int kind, input int idx, input int n);
      @(negedge clk);
      case (kind)
         0: portCntEvt[idx] = 1'b1;
         1: txDropEvt[idx] = 1'b1;
         default: rxDropEvt[idx] = 1'b1;
      endcase
      repeat (n) @(negedge clk);
      portCntEvt = '0;
      txDropEvt = 5'h00;
      rxDropEvt = 5'h00;
   endtask

   task automatic fetchPort(input int idx, input logic [31:0] e);
      int i;
      wr(`STC_REG_TABLE_SEL, `STC_SEL_PORT_CNT);
      wr(`STC_REG_ADDR_TRIG, 8'(idx));
      for (i = 0; i < 4; i++) begin
         rdChk(8'(`STC_REG_DATA_3 + i), e[31-8*i -: 8],
               "port byte");
      end
   endtask

   task automatic fetchDrop(input int ofs, input logic [15:0] e);
      wr(`STC_REG_TABLE_SEL, `STC_SEL_DROP_CNT);
      wr(`STC_REG_ADDR_TRIG, 8'(ofs));
      rdChk(`STC_REG_DATA_1, e[15:8], "drop high byte");
      rdChk(`STC_REG_DATA_0, e[7:0], "drop low byte");
   endtask

   // In-range per-port word: overflow clear, valid set, count below
   function automatic logic [31:0] pw(input int c);
      return {1'b0, 1'b1, 30'(c)};
   endfunction

   // Count of 1 to 4 from port plus offset, so a port base or offset off by one shows
   function automatic int cnt(input int p, input int o);
      return (p + o) % 4 + 1;
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      int p;
      int o;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      rdChk(`STC_REG_TABLE_SEL, 8'h00, "select after reset");
      rdChk(`STC_REG_ADDR_TRIG, 8'h00, "trigger after reset");
      rdChk(`STC_REG_DATA_3, 8'h00, "data after reset");
      rdChk(8'h70, 8'h00, "unmapped read");

      // Every counter of every port, each with a count of 1 to 4
      for (p = 0; p < 5; p++)
         for (o = 0; o < 32; o++)
            pulse(0, p * 32 + o, cnt(p, o));
      // One sweep reads every counter far inside the read interval
      for (p = 0; p < 5; p++)
         for (o = 0; o < 32; o++)
            fetchPort(p * 32 + o, pw(cnt(p, o)));
      rdChk(`STC_REG_TABLE_SEL, `STC_SEL_PORT_CNT, "select readback");
      rdChk(`STC_REG_ADDR_TRIG, 8'h9F, "trigger readback");

      // Second fetch of a counter sees it cleared
      fetchPort(32'h2E, pw(0));

      // Data reads return the captured word and clear nothing
      pulse(0, 32'h2E, 3);
      fetchPort(32'h2E, pw(3));
      pulse(0, 32'h2E, 2);
      rdChk(`STC_REG_DATA_0, 8'h03, "reread low byte");
      rdChk(`STC_REG_DATA_3, 8'h40, "reread top byte");
      fetchPort(32'h2E, pw(2));

      // Offsets past port 4 are not counters
      fetchPort(32'hA0, 32'h0000_0000);
      fetchPort(32'hFF, 32'h0000_0000);

      // Dropped-packet counters, both directions, receive ones read twice
      for (p = 0; p < 5; p++) begin
         pulse(1, p, p + 1);
         pulse(2, p, p + 6);
      end
      for (p = 0; p < 5; p++) begin
         fetchDrop(p, 16'(p + 1));
         fetchDrop(p + 5, 16'(p + 6));
      end
      rdChk(`STC_REG_DATA_3, 8'h00, "drop top byte");
      rdChk(`STC_REG_DATA_2, 8'h00, "drop second byte");
      for (p = 0; p < 5; p++)
         fetchDrop(p + 5, 16'(p + 6));

      // Foreign table code stores the trigger byte and nothing else
      pulse(0, 32'h2E, 1);
      wr(`STC_REG_TABLE_SEL, 8'h00);
      wr(`STC_REG_ADDR_TRIG, 8'h2E);
      rdChk(`STC_REG_ADDR_TRIG, 8'h2E, "foreign trigger");
      rdChk(`STC_REG_DATA_0, 8'h0A, "foreign word kept");
      fetchDrop(10, 16'h0000);
      fetchPort(32'h2E, pw(1));

      // Reset in mid-run clears the counters
      pulse(0, 5, 4);
      @(negedge clk);
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      rdChk(`STC_REG_TABLE_SEL, 8'h00, "select after second reset");
      rdChk(`STC_REG_DATA_3, 8'h00, "data after second reset");
      fetchPort(5, pw(0));
      endOfTest();
   end

endmodule
